// File: design/dpcfg_pkg.sv
// package for the datapath configuration register block
// assumes a single 250 MHz core clock and an APB register port with 32-bit data
package dpcfg_pkg;

  // ****************************************************************
  // bus layout
  // ****************************************************************
  localparam int DPCFG_ADDR_W = 8;
  localparam int DPCFG_DATA_W = 32;
  localparam logic [7:0] DPCFG_CFG_OFS = 8'h00;
  localparam logic [7:0] DPCFG_STAT_OFS = 8'h04;

  // ****************************************************************
  // configuration register fields
  // ****************************************************************
  localparam int DPCFG_REG_W = 16;
  localparam logic [15:0] DPCFG_CFG_RST = 16'h0000;
  localparam int DPCFG_INTEG_BIT = 0;
  localparam int DPCFG_SWAP_BIT = 3;
  localparam int DPCFG_VGND_BIT = 4;
  localparam int DPCFG_IGND_BIT = 5;
  localparam int DPCFG_FAST_BIT = 6;
  localparam int DPCFG_SRST_BIT = 7;
  localparam int DPCFG_PAIR_A_LSB = 8;
  localparam int DPCFG_PAIR_B_LSB = 10;
  localparam int DPCFG_PAIR_C_LSB = 12;
  // reserved bits 2:1 and 15:14 are not stored and read as zero
  localparam logic [15:0] DPCFG_CFG_WMASK = 16'h3FF9;

  // ****************************************************************
  // status register fields
  // ****************************************************************
  localparam int DPCFG_ST_BUSY_BIT = 0;
  localparam int DPCFG_ST_PAIR_A_LSB = 8;
  localparam int DPCFG_ST_PAIR_B_LSB = 10;
  localparam int DPCFG_ST_PAIR_C_LSB = 12;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int DPCFG_CLK_PERIOD_PS = 4000;
  localparam int DPCFG_SRST_TIME_NS = 1000;
  localparam int DPCFG_SRST_CYCLES = (DPCFG_SRST_TIME_NS * 1000 + DPCFG_CLK_PERIOD_PS - 1) / DPCFG_CLK_PERIOD_PS;

  // ****************************************************************
  // types
  // ****************************************************************
  localparam int DPCFG_SAMPLE_W = 24;
  localparam logic [DPCFG_SAMPLE_W-1:0] DPCFG_ZERO_SAMPLE = 24'h000000;

  typedef enum logic [1:0] {
    DPCFG_PAIR_DIRECT,
    DPCFG_PAIR_NEXT,
    DPCFG_PAIR_PREV,
    DPCFG_PAIR_RSVD
  } dpcfg_pair_t;

  typedef struct packed {
    logic [DPCFG_SAMPLE_W-1:0] a;
    logic [DPCFG_SAMPLE_W-1:0] b;
    logic [DPCFG_SAMPLE_W-1:0] c;
  } dpcfg_tri_t;

  typedef struct packed {
    dpcfg_pair_t pair_c;
    dpcfg_pair_t pair_b;
    dpcfg_pair_t pair_a;
    logic soft_reset_trigger;
    logic fast_port_enable;
    logic current_adc_ground;
    logic voltage_adc_ground;
    logic channel_exchange;
    logic integrator_enable;
  } dpcfg_ctrl_t;

endpackage : dpcfg_pkg

// File: design/dpcfg_datapath_config.sv
// datapath configuration register with its channel steering, grounding and pin selection
// assumes APB3 master on core_clk_in; all sample and pulse inputs come from logic on the same clock
// assumes the converters, integrator and power path sit outside and consume the registered outputs
// Functional notes
// - integrator_enable at bit 0 sends the three phase currents and the neutral through the integrator, else bypasses it.
// - the channel exchange bit at bit 3 puts current results in the voltage channel outputs and voltage results in the current ones.
// - voltage_adc_ground at bit 4 makes the voltage converter outputs read as grounded inputs.
// - current_adc_ground at bit 5 makes the current converter outputs read as grounded inputs.
// - fast_port_enable at bit 6 enables the fast capture port and puts fast_port_clock on the shared pin.
// - with fast_port_enable low the port is disabled and the shared pin carries third_pulse_output.
// - writing 1 to soft_reset_trigger at bit 7 starts a software reset.
// - phase_a_voltage_select at bits 9:8 pairs phase A current with voltage A, B or C for codes 00, 01, 10.
// - phase_b_voltage_select at bits 11:10 pairs phase B current with voltage B, C or A for codes 00, 01, 10.
// - phase_c_voltage_select at bits 13:12 pairs phase C current with voltage C, A or B for codes 00, 01, 10.
// - a pairing field holding 11 behaves as if it held 00.
// - reserved bits 2:1 and 15:14 have no effect whatever is written.
// - at reset every field is zero.
`timescale 1ns/1ps

module dpcfg_datapath_config
  import dpcfg_pkg::*;
#(
  parameter int SRST_CYCLES = DPCFG_SRST_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [DPCFG_ADDR_W-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [DPCFG_DATA_W-1:0] pwdata_in,
  output logic [DPCFG_DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire dpcfg_tri_t volt_adc_in,
  input wire dpcfg_tri_t curr_adc_in,
  input wire logic [DPCFG_SAMPLE_W-1:0] neut_adc_in,
  input wire dpcfg_tri_t curr_integ_in,
  input wire logic [DPCFG_SAMPLE_W-1:0] neut_integ_in,
  input wire logic fast_port_clock_in,
  input wire logic third_pulse_output_in,
  output dpcfg_tri_t volt_chan_out,
  output dpcfg_tri_t curr_chan_out,
  output logic [DPCFG_SAMPLE_W-1:0] neut_chan_out,
  output dpcfg_tri_t pair_volt_out,
  output dpcfg_tri_t pair_curr_out,
  output logic shared_pin_out,
  output logic fast_port_enable_out,
  output logic integrator_enable_out,
  output logic soft_reset_out,
  output dpcfg_ctrl_t ctrl_out
);

  // ****************************************************************
  // counter width for the software reset hold
  // ****************************************************************
  localparam int SRST_CNT_W = $clog2(SRST_CYCLES + 1);
  localparam logic [SRST_CNT_W-1:0] SRST_LOAD = SRST_CNT_W'(SRST_CYCLES);
  localparam logic [SRST_CNT_W-1:0] SRST_ONE = SRST_CNT_W'(1);

  // ****************************************************************
  // state
  // ****************************************************************
  dpcfg_ctrl_t ctrl_reg;
  dpcfg_ctrl_t ctrl_next;
  logic [SRST_CNT_W-1:0] srst_cnt_reg;
  logic [DPCFG_DATA_W-1:0] rdata_reg;
  logic [DPCFG_DATA_W-1:0] rdata_next;
  dpcfg_tri_t volt_chan_reg;
  dpcfg_tri_t curr_chan_reg;
  logic [DPCFG_SAMPLE_W-1:0] neut_chan_reg;
  dpcfg_tri_t pair_volt_reg;
  dpcfg_tri_t pair_curr_reg;
  logic shared_pin_reg;

  logic setup_phase;
  logic access_phase;
  logic cfg_hit;
  logic stat_hit;
  logic addr_ok;
  logic cfg_write;
  logic srst_start;
  logic srst_busy;
  logic srst_last;
  logic read_setup;
  logic [15:0] cfg_word;
  logic [15:0] stat_word;
  dpcfg_pair_t eff_a;
  dpcfg_pair_t eff_b;
  dpcfg_pair_t eff_c;
  dpcfg_tri_t volt_gnd;
  dpcfg_tri_t curr_gnd;
  dpcfg_tri_t curr_sel;
  logic [DPCFG_SAMPLE_W-1:0] neut_sel;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // reserved code collapses onto the direct pairing
  function automatic dpcfg_pair_t pair_fold(input dpcfg_pair_t code);
    dpcfg_pair_t res;
    res = code;
    if (code == DPCFG_PAIR_RSVD) begin
      res = DPCFG_PAIR_DIRECT;
    end
    return res;
  endfunction : pair_fold

  // picks own, next or previous phase voltage; phases ordered a, b, c cyclically
  function automatic logic [DPCFG_SAMPLE_W-1:0] pair_pick(
    input dpcfg_pair_t code,
    input logic [DPCFG_SAMPLE_W-1:0] own,
    input logic [DPCFG_SAMPLE_W-1:0] nxt,
    input logic [DPCFG_SAMPLE_W-1:0] prv
  );
    logic [DPCFG_SAMPLE_W-1:0] res;
    res = own;
    unique case (code)
      DPCFG_PAIR_DIRECT: res = own;
      DPCFG_PAIR_NEXT: res = nxt;
      DPCFG_PAIR_PREV: res = prv;
      DPCFG_PAIR_RSVD: res = own;
    endcase
    return res;
  endfunction : pair_pick

  // ****************************************************************
  // apb decode
  // ****************************************************************
  assign setup_phase = psel_in && !penable_in;
  assign access_phase = psel_in && penable_in;
  assign cfg_hit = (paddr_in == DPCFG_CFG_OFS);
  assign stat_hit = (paddr_in == DPCFG_STAT_OFS);
  assign addr_ok = cfg_hit || stat_hit;
  // zero wait states: every access phase completes on its first edge
  assign pready_out = 1'b1;
  assign pslverr_out = access_phase && !addr_ok;
  // status writes are dropped without an error, the word is read-only
  assign cfg_write = access_phase && pwrite_in && cfg_hit;
  assign read_setup = setup_phase && !pwrite_in;
  assign prdata_out = rdata_reg;

  // ****************************************************************
  // register views
  // ****************************************************************
  assign srst_busy = (srst_cnt_reg != '0);
  // last busy cycle: the trigger bit drops together with the busy flag
  assign srst_last = (srst_cnt_reg == SRST_ONE);
  // status shows the folded codes, which is what the power path really uses
  assign eff_a = pair_fold(ctrl_reg.pair_a);
  assign eff_b = pair_fold(ctrl_reg.pair_b);
  assign eff_c = pair_fold(ctrl_reg.pair_c);

  always_comb begin
    cfg_word = '0;
    cfg_word[DPCFG_INTEG_BIT] = ctrl_reg.integrator_enable;
    cfg_word[DPCFG_SWAP_BIT] = ctrl_reg.channel_exchange;
    cfg_word[DPCFG_VGND_BIT] = ctrl_reg.voltage_adc_ground;
    cfg_word[DPCFG_IGND_BIT] = ctrl_reg.current_adc_ground;
    cfg_word[DPCFG_FAST_BIT] = ctrl_reg.fast_port_enable;
    cfg_word[DPCFG_SRST_BIT] = ctrl_reg.soft_reset_trigger;
    cfg_word[DPCFG_PAIR_A_LSB +: 2] = ctrl_reg.pair_a;
    cfg_word[DPCFG_PAIR_B_LSB +: 2] = ctrl_reg.pair_b;
    cfg_word[DPCFG_PAIR_C_LSB +: 2] = ctrl_reg.pair_c;
  end

  always_comb begin
    stat_word = '0;
    stat_word[DPCFG_ST_BUSY_BIT] = srst_busy;
    stat_word[DPCFG_ST_PAIR_A_LSB +: 2] = eff_a;
    stat_word[DPCFG_ST_PAIR_B_LSB +: 2] = eff_b;
    stat_word[DPCFG_ST_PAIR_C_LSB +: 2] = eff_c;
  end

  // ****************************************************************
  // configuration register
  // ****************************************************************
  // reserved bits are dropped by the write mask, so they never reach any logic
  always_comb begin
    logic [15:0] wd;
    wd = pwdata_in[DPCFG_REG_W-1:0] & DPCFG_CFG_WMASK;
    ctrl_next = ctrl_reg;
    if (cfg_write) begin
      ctrl_next.integrator_enable = wd[DPCFG_INTEG_BIT];
      ctrl_next.channel_exchange = wd[DPCFG_SWAP_BIT];
      ctrl_next.voltage_adc_ground = wd[DPCFG_VGND_BIT];
      ctrl_next.current_adc_ground = wd[DPCFG_IGND_BIT];
      ctrl_next.fast_port_enable = wd[DPCFG_FAST_BIT];
      // pairing codes are stored raw so software reads back what it wrote
      ctrl_next.pair_a = dpcfg_pair_t'(wd[DPCFG_PAIR_A_LSB +: 2]);
      ctrl_next.pair_b = dpcfg_pair_t'(wd[DPCFG_PAIR_B_LSB +: 2]);
      ctrl_next.pair_c = dpcfg_pair_t'(wd[DPCFG_PAIR_C_LSB +: 2]);
      // writing 0 while a reset runs does not cut it short
      if (wd[DPCFG_SRST_BIT]) begin
        ctrl_next.soft_reset_trigger = 1'b1;
      end
    end
    // a trigger written while a reset runs is dropped, its last cycle included,
    // so the bit can never outlive the reset that it reports
    if (srst_last) begin
      ctrl_next.soft_reset_trigger = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= dpcfg_ctrl_t'(DPCFG_CFG_RST[$bits(dpcfg_ctrl_t)-1:0]);
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ****************************************************************
  // software reset sequencer
  // ****************************************************************
  assign srst_start = cfg_write && pwdata_in[DPCFG_SRST_BIT] && !srst_busy;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      srst_cnt_reg <= '0;
    end else if (srst_start) begin
      srst_cnt_reg <= SRST_LOAD;
    end else if (srst_busy) begin
      srst_cnt_reg <= srst_cnt_reg - SRST_ONE;
    end
  end

  // the other fields keep their values across a software reset
  assign soft_reset_out = srst_busy;

  // ****************************************************************
  // read data, captured in the setup cycle
  // ****************************************************************
  // capturing early lets the access phase finish with no wait state
  always_comb begin
    rdata_next = rdata_reg;
    if (read_setup) begin
      if (cfg_hit) begin
        rdata_next = {16'h0000, cfg_word};
      end else if (stat_hit) begin
        rdata_next = {16'h0000, stat_word};
      end else begin
        rdata_next = '0;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************************
  // converter grounding and integrator selection
  // ****************************************************************
  always_comb begin
    volt_gnd = volt_adc_in;
    if (ctrl_reg.voltage_adc_ground) begin
      volt_gnd = '{DPCFG_ZERO_SAMPLE, DPCFG_ZERO_SAMPLE, DPCFG_ZERO_SAMPLE};
    end
  end

  // grounding acts after the integrator selection, so it zeroes either source
  always_comb begin
    curr_gnd = ctrl_reg.integrator_enable ? curr_integ_in : curr_adc_in;
    neut_sel = ctrl_reg.integrator_enable ? neut_integ_in : neut_adc_in;
    if (ctrl_reg.current_adc_ground) begin
      curr_gnd = '{DPCFG_ZERO_SAMPLE, DPCFG_ZERO_SAMPLE, DPCFG_ZERO_SAMPLE};
      neut_sel = DPCFG_ZERO_SAMPLE;
    end
    curr_sel = curr_gnd;
  end

  // ****************************************************************
  // channel results
  // ****************************************************************
  // neutral has no voltage partner, so exchange only moves the three phases
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      volt_chan_reg <= '0;
      curr_chan_reg <= '0;
      neut_chan_reg <= '0;
    end else begin
      neut_chan_reg <= neut_sel;
      if (ctrl_reg.channel_exchange) begin
        volt_chan_reg <= curr_sel;
        curr_chan_reg <= volt_gnd;
      end else begin
        volt_chan_reg <= volt_gnd;
        curr_chan_reg <= curr_sel;
      end
    end
  end

  // ****************************************************************
  // power path pairing
  // ****************************************************************
  // the power path works on true channels, independent of the exchange bit
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pair_volt_reg <= '0;
      pair_curr_reg <= '0;
    end else begin
      pair_curr_reg <= curr_sel;
      pair_volt_reg.a <= pair_pick(eff_a, volt_gnd.a, volt_gnd.b, volt_gnd.c);
      pair_volt_reg.b <= pair_pick(eff_b, volt_gnd.b, volt_gnd.c, volt_gnd.a);
      pair_volt_reg.c <= pair_pick(eff_c, volt_gnd.c, volt_gnd.a, volt_gnd.b);
    end
  end

  // ****************************************************************
  // shared pin
  // ****************************************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shared_pin_reg <= 1'b0;
    end else if (ctrl_reg.fast_port_enable) begin
      shared_pin_reg <= fast_port_clock_in;
    end else begin
      shared_pin_reg <= third_pulse_output_in;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign volt_chan_out = volt_chan_reg;
  assign curr_chan_out = curr_chan_reg;
  assign neut_chan_out = neut_chan_reg;
  assign pair_volt_out = pair_volt_reg;
  assign pair_curr_out = pair_curr_reg;
  // the pin is registered so a change of source never glitches the pad
  assign shared_pin_out = shared_pin_reg;
  assign fast_port_enable_out = ctrl_reg.fast_port_enable;
  assign integrator_enable_out = ctrl_reg.integrator_enable;
  assign ctrl_out = ctrl_reg;

endmodule : dpcfg_datapath_config

// File: testbench/dpcfg_datapath_config_checker.sv
// checker for the datapath configuration register block
// assumes it is bound to dpcfg_datapath_config and sees only its ports
`timescale 1ns/1ps
module dpcfg_datapath_config_checker
  import dpcfg_pkg::*;
#(
  parameter int SRST_CYCLES = DPCFG_SRST_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [DPCFG_ADDR_W-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [DPCFG_DATA_W-1:0] pwdata_in,
  input wire dpcfg_tri_t volt_adc_in,
  input wire dpcfg_tri_t curr_adc_in,
  input wire dpcfg_tri_t curr_integ_in,
  input wire logic [DPCFG_SAMPLE_W-1:0] neut_integ_in,
  input wire logic fast_port_clock_in,
  input wire logic third_pulse_output_in,
  input wire dpcfg_tri_t volt_chan_out,
  input wire dpcfg_tri_t curr_chan_out,
  input wire logic [DPCFG_SAMPLE_W-1:0] neut_chan_out,
  input wire dpcfg_tri_t pair_volt_out,
  input wire logic shared_pin_out,
  input wire logic fast_port_enable_out,
  input wire logic soft_reset_out,
  input wire dpcfg_ctrl_t ctrl_out
);
  // ****************
  // helper state
  // ****************
  // vld masks the first edge after reset, where the delayed copies are stale
  logic vld;
  logic pin_q;
  int unsigned hi_cnt;
  dpcfg_ctrl_t c_q;
  dpcfg_tri_t v_q, i_q, g_q;
  logic [DPCFG_SAMPLE_W-1:0] n_q;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vld <= 1'b0;
      hi_cnt <= 0;
    end else begin
      vld <= 1'b1;
      hi_cnt <= soft_reset_out ? hi_cnt + 1 : 0;
    end
  end
  always_ff @(posedge core_clk_in) begin
    c_q <= ctrl_out;
    v_q <= volt_adc_in;
    i_q <= curr_adc_in;
    g_q <= curr_integ_in;
    n_q <= neut_integ_in;
    pin_q <= fast_port_enable_out ? fast_port_clock_in : third_pulse_output_in;
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_srst_write;
    psel_in && penable_in && pwrite_in && paddr_in == DPCFG_CFG_OFS && pwdata_in[DPCFG_SRST_BIT];
  endsequence
  sequence s_srst_idle;
    !soft_reset_out;
  endsequence
  property p_srst_start;
    s_srst_write ##0 s_srst_idle |=> soft_reset_out;
  endproperty
  property p_srst_len;
    $fell(soft_reset_out) |-> hi_cnt == SRST_CYCLES;
  endproperty
  property p_srst_bound;
    soft_reset_out |-> hi_cnt < SRST_CYCLES;
  endproperty
  property p_srst_bit;
    soft_reset_out == ctrl_out.soft_reset_trigger;
  endproperty
  property p_pin;
    vld |-> shared_pin_out == pin_q;
  endproperty
  property p_integ;
    vld && c_q.integrator_enable && !c_q.channel_exchange && !c_q.current_adc_ground
      |-> curr_chan_out == g_q && neut_chan_out == n_q;
  endproperty
  property p_swap;
    vld && c_q.channel_exchange && !c_q.integrator_enable && !c_q.voltage_adc_ground && !c_q.current_adc_ground
      |-> volt_chan_out == i_q && curr_chan_out == v_q;
  endproperty
  property p_vgnd;
    vld && c_q.voltage_adc_ground && !c_q.channel_exchange |-> volt_chan_out == '0;
  endproperty
  property p_ignd;
    vld && c_q.current_adc_ground && !c_q.channel_exchange |-> curr_chan_out == '0 && neut_chan_out == '0;
  endproperty
  property p_pair_a;
    vld && !c_q.voltage_adc_ground && c_q.pair_a inside {DPCFG_PAIR_DIRECT, DPCFG_PAIR_RSVD}
      |-> pair_volt_out.a == v_q.a;
  endproperty
  property p_pair_b;
    vld && !c_q.voltage_adc_ground && c_q.pair_b == DPCFG_PAIR_NEXT |-> pair_volt_out.b == v_q.c;
  endproperty
  property p_pair_c;
    vld && !c_q.voltage_adc_ground && c_q.pair_c == DPCFG_PAIR_PREV |-> pair_volt_out.c == v_q.b;
  endproperty
  a_srst_start: assert property (p_srst_start) else $error("soft reset did not start");
  a_srst_len: assert property (p_srst_len) else $error("soft reset length wrong");
  a_srst_bound: assert property (p_srst_bound) else $error("soft reset overran");
  a_srst_bit: assert property (p_srst_bit) else $error("trigger bit out of step");
  a_pin: assert property (p_pin) else $error("shared pin source wrong");
  a_integ: assert property (p_integ) else $error("integrator path wrong");
  a_swap: assert property (p_swap) else $error("channel exchange wrong");
  a_vgnd: assert property (p_vgnd) else $error("voltage not grounded");
  a_ignd: assert property (p_ignd) else $error("current not grounded");
  a_pair_a: assert property (p_pair_a) else $error("phase a pairing wrong");
  a_pair_b: assert property (p_pair_b) else $error("phase b pairing wrong");
  a_pair_c: assert property (p_pair_c) else $error("phase c pairing wrong");
endmodule : dpcfg_datapath_config_checker

bind dpcfg_datapath_config dpcfg_datapath_config_checker #(.SRST_CYCLES(SRST_CYCLES)) u_chk (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .paddr_in(paddr_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .pwdata_in(pwdata_in), .volt_adc_in(volt_adc_in),
  .curr_adc_in(curr_adc_in), .curr_integ_in(curr_integ_in), .neut_integ_in(neut_integ_in),
  .fast_port_clock_in(fast_port_clock_in), .third_pulse_output_in(third_pulse_output_in),
  .volt_chan_out(volt_chan_out), .curr_chan_out(curr_chan_out), .neut_chan_out(neut_chan_out),
  .pair_volt_out(pair_volt_out), .shared_pin_out(shared_pin_out),
  .fast_port_enable_out(fast_port_enable_out), .soft_reset_out(soft_reset_out), .ctrl_out(ctrl_out));

// File: testbench/dpcfg_datapath_config_bench.sv
// self-checking bench for the datapath configuration register
// assumes the design package is compiled first; the short soft reset keeps the run brief
`timescale 1ns/1ps
module datapath_config_register_bench
  import dpcfg_pkg::*;
;
  localparam int SRST = 4;
  logic clk, rst_n, psel, penable, pwrite, fclk, cf3;
  logic [7:0] paddr;
  logic [31:0] pwdata, r;
  logic e;
  dpcfg_tri_t vin, iin, gin, vch, ich, pv, pc;
  logic [23:0] na, ng, nch;
  logic pready, pslverr, pin, fen, ien, srst;
  logic [31:0] prdata;
  dpcfg_ctrl_t ctrl;
  int error_cnt = 0;
  int comparisons = 0;
  int k;
  logic [15:0] dcfg [5] = '{16'h0001, 16'h0008, 16'h0010, 16'h0020, 16'h0019};
  logic [15:0] pcfg [5] = '{16'h0000, 16'h1500, 16'h2A00, 16'h3F00, 16'h2100};

  dpcfg_datapath_config #(.SRST_CYCLES(SRST)) i_dut (
    .core_clk_in(clk), .rst_n_in(rst_n), .paddr_in(paddr), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .volt_adc_in(vin), .curr_adc_in(iin), .neut_adc_in(na), .curr_integ_in(gin), .neut_integ_in(ng),
    .fast_port_clock_in(fclk), .third_pulse_output_in(cf3), .volt_chan_out(vch), .curr_chan_out(ich),
    .neut_chan_out(nch), .pair_volt_out(pv), .pair_curr_out(pc), .shared_pin_out(pin),
    .fast_port_enable_out(fen), .integrator_enable_out(ien), .soft_reset_out(srst), .ctrl_out(ctrl));

  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [167:0] got, input logic [167:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // starts on a fresh edge so psel is never driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd_chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  function automatic logic [167:0] exp_chan(input logic [15:0] c);
    dpcfg_tri_t v, i;
    logic [23:0] n;
    v = c[4] ? '0 : vin;
    i = c[5] ? '0 : (c[0] ? gin : iin);
    n = c[5] ? '0 : (c[0] ? ng : na);
    return c[3] ? {i, v, n} : {v, i, n};
  endfunction : exp_chan
  function automatic dpcfg_tri_t exp_pair(input logic [15:0] c);
    logic [23:0] v [3];
    int s;
    dpcfg_tri_t q;
    v = '{vin.a, vin.b, vin.c};
    for (int p = 0; p < 3; p++) begin
      s = c[8+2*p +: 2];
      s = (s == 3) ? p : (p + s) % 3;
      q[71-24*p -: 24] = v[s];
    end
    return q;
  endfunction : exp_pair
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // ****************
  // clock, reset, watchdog
  // ****************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #20000;
    error_cnt++;
    $display("[ERR] t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  // ****************
  // tests
  // ****************
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, fclk, cf3} = '0;
    vin = {24'h111111, 24'h222222, 24'h333333};
    iin = {24'h444444, 24'h555555, 24'h666666};
    gin = {24'h777777, 24'h888888, 24'h999999};
    na = 24'hAAAAAA;
    ng = 24'hBBBBBB;
    cyc(8);
    rst_n <= 1'b1;
    chk(ctrl, 0);
    rd_chk(DPCFG_CFG_OFS, 32'h0);
    $display("test reset done");
    apb(1'b1, DPCFG_CFG_OFS, 32'hFFFF_FF7F);
    rd_chk(DPCFG_CFG_OFS, 32'h0000_3F79);
    rd_chk(DPCFG_STAT_OFS, 32'h0);
    apb(1'b1, DPCFG_CFG_OFS, 32'h0000_C006);
    cyc(2);
    chk({vch, ich, nch}, exp_chan(16'h0));
    apb(1'b0, 8'h08, 32'h0);
    chk({e, r}, {1'b1, 32'h0});
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b1, DPCFG_STAT_OFS, 32'h1);
    rd_chk(DPCFG_CFG_OFS, 32'h0);
    $display("test reserved done");
    foreach (dcfg[j]) begin
      vin <= ~vin;
      gin <= ~gin;
      apb(1'b1, DPCFG_CFG_OFS, {16'h0, dcfg[j]});
      cyc(2);
      chk({vch, ich, nch}, exp_chan(dcfg[j]));
      chk(ien, dcfg[j][0]);
    end
    $display("test datapath done");
    foreach (pcfg[j]) begin
      vin <= {vin.c, vin.a, vin.b};
      apb(1'b1, DPCFG_CFG_OFS, {16'h0, pcfg[j]});
      cyc(2);
      chk(pv, exp_pair(pcfg[j]));
      chk(pc, iin);
    end
    $display("test pairing done");
    for (int f = 0; f < 2; f++) begin
      for (int b = 0; b < 2; b++) begin
        apb(1'b1, DPCFG_CFG_OFS, f << 6);
        fclk <= b[0];
        cf3 <= !b[0];
        cyc(2);
        chk({fen, pin}, {f[0], f[0] ? b[0] : !b[0]});
      end
    end
    $display("test shared pin done");
    apb(1'b1, DPCFG_CFG_OFS, 32'h0000_0081);
    cyc(1);
    chk({srst, ctrl.soft_reset_trigger}, 2'b11);
    k = 0;
    while (srst === 1'b1 && k < 100) begin
      k++;
      @(posedge clk);
    end
    chk(k, SRST);
    rd_chk(DPCFG_CFG_OFS, 32'h1);
    apb(1'b1, DPCFG_CFG_OFS, 32'h1);
    cyc(1);
    chk(srst, 1'b0);
    $display("test soft reset done");
    tally_and_finish();
  end
endmodule : datapath_config_register_bench
